// ==== hdl/uart_ctl_map.vh ====
`ifndef UART_CTL_MAP_VH
`define UART_CTL_MAP_VH

// register offsets on the plain register port
`define ADDR_IDENT 3'h0
`define ADDR_FIFO_CTL 3'h1
`define ADDR_LINE_FMT 3'h2
`define ADDR_ENH_FEAT 3'h3
`define ADDR_IRQ_MASK 3'h4
`define ADDR_FEAT_CTL 3'h5
`define ADDR_TRIG_LVL 3'h6
`define ADDR_STATUS 3'h7

// fifo_control_reg fields
`define FC_ENABLE 0
`define FC_RX_RST 1
`define FC_TX_RST 2
`define FC_DMA 3
`define FC_TX_SEL_LO 4
`define FC_RX_SEL_LO 6

// line_format_reg fields
`define LF_STOP 2
`define LF_PAR_EN 3
`define LF_PAR_EVEN 4

// enhanced_feature_reg and interrupt_mask_reg fields
`define EF_ENH 4
`define IM_RX 0
`define IM_TX 1
`define IM_LS 2
`define IM_MS 3
`define IM_XOFF 5
`define IM_RTS 6
`define IM_CTS 7

// feature_control_reg fields
`define FT_TABLE_LO 4
`define FT_TRG_DIR 7

// reset values
`define RST_BYTE 8'h00
`define RST_LEVEL 8'h01
`define RST_CHAR_BITS 4'h5

// identification codes, bits 5..0
`define ID_LINE 6'h06
`define ID_TIMEOUT 6'h0c
`define ID_RX_READY_PIN 6'h04
`define ID_TX_READY_PIN 6'h02
`define ID_MODEM 6'h00
`define ID_XOFF 6'h10
`define ID_FLOW 6'h20
`define ID_NONE 6'h01

// trigger tables, code 00..11 in order
`define TBL_A 2'h0
`define TBL_B 2'h1
`define TBL_C 2'h2
`define TBL_D 2'h3

`endif

// ==== hdl/irq_prio_enc.v ====
`timescale 1ns/1ps
module irq_prio_enc
(
  input wire [6:0] pend_in,
  output reg [5:0] code_out
);
`include "uart_ctl_map.vh"

  // index 0 is level 1, index 6 is level 7
  always @*
  begin
    if (pend_in[0])
      code_out = `ID_LINE;
    else if (pend_in[1])
      code_out = `ID_TIMEOUT;
    else if (pend_in[2])
      code_out = `ID_RX_READY_PIN;
    else if (pend_in[3])
      code_out = `ID_TX_READY_PIN;
    else if (pend_in[4])
      code_out = `ID_MODEM;
    else if (pend_in[5])
      code_out = `ID_XOFF;
    else if (pend_in[6])
      code_out = `ID_FLOW;
    else
      code_out = `ID_NONE;
  end

endmodule // irq_prio_enc

// ==== hdl/trig_level_sel.v ====
`timescale 1ns/1ps
module trig_level_sel
(
  input wire [1:0] table_in,
  input wire [1:0] rx_sel_in,
  input wire [1:0] tx_sel_in,
  input wire [7:0] rx_prog_in,
  input wire [7:0] tx_prog_in,
  output reg [7:0] rx_lvl_out,
  output reg [7:0] tx_lvl_out
);
`include "uart_ctl_map.vh"

  // one table serves both directions
  always @*
  begin
    rx_lvl_out = 8'h01;
    tx_lvl_out = 8'h01;
    case (table_in)
      `TBL_A:
      begin
        tx_lvl_out = 8'h01;
        case (rx_sel_in)
          2'h0: rx_lvl_out = 8'h01;
          2'h1: rx_lvl_out = 8'h04;
          2'h2: rx_lvl_out = 8'h08;
          default: rx_lvl_out = 8'h0e;
        endcase
      end
      `TBL_B:
      begin
        case (rx_sel_in)
          2'h0: rx_lvl_out = 8'h08;
          2'h1: rx_lvl_out = 8'h10;
          2'h2: rx_lvl_out = 8'h18;
          default: rx_lvl_out = 8'h1c;
        endcase
        case (tx_sel_in)
          2'h0: tx_lvl_out = 8'h10;
          2'h1: tx_lvl_out = 8'h08;
          2'h2: tx_lvl_out = 8'h18;
          default: tx_lvl_out = 8'h1e;
        endcase
      end
      `TBL_C:
      begin
        case (rx_sel_in)
          2'h0: rx_lvl_out = 8'h08;
          2'h1: rx_lvl_out = 8'h10;
          2'h2: rx_lvl_out = 8'h38;
          default: rx_lvl_out = 8'h3c;
        endcase
        case (tx_sel_in)
          2'h0: tx_lvl_out = 8'h08;
          2'h1: tx_lvl_out = 8'h10;
          2'h2: tx_lvl_out = 8'h20;
          default: tx_lvl_out = 8'h38;
        endcase
      end
      default:
      begin
        rx_lvl_out = rx_prog_in;
        tx_lvl_out = tx_prog_in;
      end
    endcase
  end

endmodule // trig_level_sel

// ==== hdl/uart_ctl_top.v ====
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - ident bits 5..0 encode top pending source
// - bit 0 high only when nothing pending
// - xoff/special flag needs enhance and mask enable
// - flow pin deassert flag needs enhance enable
// - ident bits 7..6 mirror fifo enable
// - fifo control bits 7..1 ignored unless bit 0 set; bit 0 always taken
// - rx fifo reset pulse, self clearing
// - tx fifo reset pulse, self clearing
// - bit 3 selects dma pin mode
// - tx irq below trigger, or on empty
// - tx trigger field needs enhance enable
// - one trigger table for both directions
// - rx irq when count reaches trigger
// - table A rx 1/4/8/14, tx 1
// - tables B and C fixed levels
// - table D levels from trigger register
// - bits 1..0 set character length 5..8
// - bit 2 gives 1.5 or 2 stop bits
// - bit 3 enables parity
// - bit 4 selects even, else odd
// - read shows only highest pending source
// - tx irq clears on ident read or holding write
module uart_ctl_top
#(
  parameter CW = 7
)
(
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire line_status_in,
  input wire rx_timeout_in,
  input wire modem_status_in,
  input wire [CW-1:0] rx_count_in,
  input wire [CW-1:0] tx_count_in,
  input wire xoff_det_in,
  input wire xon_det_in,
  input wire special_det_in,
  input wire rx_char_in,
  input wire cts_deassert_in,
  input wire rts_deassert_in,
  input wire modem_read_in,
  input wire thr_write_in,
  output reg [7:0] rdata_out,
  output reg fifo_en_out,
  output reg dma_mode_out,
  output reg rx_fifo_rst_out,
  output reg tx_fifo_rst_out,
  output reg [3:0] char_bits_out,
  output reg stop_half_out,
  output reg stop_two_out,
  output reg parity_en_out,
  output reg parity_even_out,
  output reg [7:0] rx_trig_out,
  output reg [7:0] tx_trig_out,
  output reg irq_pending_out
);
`include "uart_ctl_map.vh"

  reg fifo_en_q;
  reg dma_q;
  reg [1:0] rx_sel_q;
  reg [1:0] tx_sel_q;
  reg [7:0] line_fmt_q;
  reg [7:0] enh_q;
  reg [7:0] mask_q;
  reg [7:0] feat_q;
  reg [7:0] rx_prog_q;
  reg [7:0] tx_prog_q;
  reg tx_rdy_q;
  reg tx_filled_q;
  reg [CW-1:0] tx_count_prev_q;
  reg xoff_q;
  reg special_q;
  reg flow_q;
  reg [7:0] rdata_d;
  reg tx_rdy_d;
  wire [7:0] rx_lvl;
  wire [7:0] tx_lvl;
  wire [7:0] rx_cnt;
  wire [7:0] tx_cnt;
  wire [7:0] tx_cnt_prev;
  wire [6:0] pend;
  wire [6:0] src_raw;
  wire [6:0] src_gate;
  wire [5:0] id_code;
  wire [7:0] ident;
  wire enh_on;
  wire wr_fc;
  wire rd_id;
  wire rx_hit;
  wire tx_below;
  wire tx_empty_evt;
  wire tx_set;
  wire tx_clr;
  wire xs_clr;
  wire len_five;

  assign enh_on = enh_q[`EF_ENH];
  assign wr_fc = wr_in && (addr_in == `ADDR_FIFO_CTL);
  assign rd_id = rd_in && (addr_in == `ADDR_IDENT);
  assign rx_cnt = {{(8-CW){1'b0}}, rx_count_in};
  assign tx_cnt = {{(8-CW){1'b0}}, tx_count_in};
  assign tx_cnt_prev = {{(8-CW){1'b0}}, tx_count_prev_q};

  trig_level_sel u_trig
  (
    .table_in(feat_q[`FT_TABLE_LO+1:`FT_TABLE_LO]),
    .rx_sel_in(rx_sel_q),
    .tx_sel_in(tx_sel_q),
    .rx_prog_in(rx_prog_q),
    .tx_prog_in(tx_prog_q),
    .rx_lvl_out(rx_lvl),
    .tx_lvl_out(tx_lvl)
  );

  // rx ready: trigger level in fifo mode, any data otherwise
  assign rx_hit = fifo_en_q ? (rx_cnt >= rx_lvl) : (rx_cnt != 8'h00);

  // tx ready: below trigger after a fill past it, else on going empty
  assign tx_below = tx_filled_q && (tx_cnt < tx_lvl);
  assign tx_empty_evt = !tx_filled_q && (tx_cnt == 8'h00) && (tx_cnt_prev != 8'h00);
  assign tx_set = fifo_en_q ? (tx_below || tx_empty_evt)
                            : ((tx_cnt == 8'h00) && (tx_cnt_prev != 8'h00));

  // raw source per priority level, index 0 is level 1
  assign src_raw[0] = line_status_in;
  assign src_raw[1] = rx_timeout_in;
  assign src_raw[2] = rx_hit;
  assign src_raw[3] = tx_rdy_q;
  assign src_raw[4] = modem_status_in;
  assign src_raw[5] = xoff_q || special_q;
  assign src_raw[6] = flow_q;

  // enable per level: mask bits, enhanced mode for levels 6 and 7
  assign src_gate[0] = mask_q[`IM_LS];
  assign src_gate[1] = mask_q[`IM_RX];
  assign src_gate[2] = mask_q[`IM_RX];
  assign src_gate[3] = mask_q[`IM_TX];
  assign src_gate[4] = mask_q[`IM_MS];
  assign src_gate[5] = enh_on && mask_q[`IM_XOFF];
  assign src_gate[6] = enh_on;

  // one gate per priority level
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_pend
      assign pend[gi] = src_raw[gi] && src_gate[gi];
    end
  endgenerate

  // code follows the live pending set, so a cleared source gives way at once
  irq_prio_enc u_enc
  (
    .pend_in(pend),
    .code_out(id_code)
  );

  assign ident = {fifo_en_q, fifo_en_q, id_code};

  // an ident read clears the tx ready or xoff/special source only when it reports it; the rest stay queued
  assign tx_clr = (rd_id && (id_code == `ID_TX_READY_PIN)) || thr_write_in;
  assign xs_clr = rd_id && (id_code == `ID_XOFF);

  assign len_five = (line_fmt_q[1:0] == 2'h0);

  // fifo control register, write only
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fifo_en_q <= 1'b0;
      dma_q <= 1'b0;
      rx_sel_q <= 2'h0;
      tx_sel_q <= 2'h0;
      rx_fifo_rst_out <= 1'b0;
      tx_fifo_rst_out <= 1'b0;
    end
    else
    begin
      rx_fifo_rst_out <= 1'b0;
      tx_fifo_rst_out <= 1'b0;
      if (wr_fc)
      begin
        fifo_en_q <= wdata_in[`FC_ENABLE];
        if (wdata_in[`FC_ENABLE])
        begin
          rx_fifo_rst_out <= wdata_in[`FC_RX_RST];
          tx_fifo_rst_out <= wdata_in[`FC_TX_RST];
          dma_q <= wdata_in[`FC_DMA];
          rx_sel_q <= wdata_in[`FC_RX_SEL_LO+1:`FC_RX_SEL_LO];
          if (enh_on)
            tx_sel_q <= wdata_in[`FC_TX_SEL_LO+1:`FC_TX_SEL_LO];
        end
      end
    end
  end

  // line format, enhanced feature, mask, feature control, trigger level
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      line_fmt_q <= `RST_BYTE;
      enh_q <= `RST_BYTE;
      mask_q <= `RST_BYTE;
      feat_q <= `RST_BYTE;
      rx_prog_q <= `RST_LEVEL;
      tx_prog_q <= `RST_LEVEL;
    end
    else if (wr_in)
    begin
      case (addr_in)
        `ADDR_LINE_FMT: line_fmt_q <= wdata_in;
        `ADDR_ENH_FEAT: enh_q <= wdata_in;
        `ADDR_IRQ_MASK: mask_q <= wdata_in;
        `ADDR_FEAT_CTL: feat_q <= wdata_in;
        `ADDR_TRIG_LVL:
        begin
          if (feat_q[`FT_TRG_DIR])
            tx_prog_q <= wdata_in;
          else
            rx_prog_q <= wdata_in;
        end
        default:
        begin
          line_fmt_q <= line_fmt_q;
        end
      endcase
    end
  end

  // transmit ready next value; a new event beats a same-cycle clear
  always @*
  begin
    tx_rdy_d = tx_rdy_q;
    if (tx_set)
      tx_rdy_d = 1'b1;
    else if (tx_clr)
      tx_rdy_d = 1'b0;
  end

  // transmit ready tracking
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_rdy_q <= 1'b0;
      tx_filled_q <= 1'b0;
      tx_count_prev_q <= {CW{1'b0}};
    end
    else
    begin
      tx_count_prev_q <= tx_count_in;
      if (tx_cnt > tx_lvl)
        tx_filled_q <= 1'b1;
      else if (tx_below || (tx_cnt == 8'h00))
        tx_filled_q <= 1'b0;
      tx_rdy_q <= tx_rdy_d;
    end
  end

  // xoff, special character and flow pin flags
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      xoff_q <= 1'b0;
      special_q <= 1'b0;
      flow_q <= 1'b0;
    end
    else
    begin
      if (xoff_det_in && enh_on && mask_q[`IM_XOFF])
        xoff_q <= 1'b1;
      else if (xs_clr || xon_det_in)
        xoff_q <= 1'b0;
      if (special_det_in && enh_on && mask_q[`IM_XOFF])
        special_q <= 1'b1;
      else if (xs_clr || rx_char_in)
        special_q <= 1'b0;
      if (enh_on && ((cts_deassert_in && mask_q[`IM_CTS]) || (rts_deassert_in && mask_q[`IM_RTS])))
        flow_q <= 1'b1;
      else if (modem_read_in)
        flow_q <= 1'b0;
    end
  end

  // read data mux
  always @*
  begin
    rdata_d = 8'h00;
    case (addr_in)
      `ADDR_IDENT: rdata_d = ident;
      `ADDR_LINE_FMT: rdata_d = line_fmt_q;
      `ADDR_ENH_FEAT: rdata_d = enh_q;
      `ADDR_IRQ_MASK: rdata_d = mask_q;
      `ADDR_FEAT_CTL: rdata_d = feat_q;
      `ADDR_STATUS: rdata_d = {4'h0, tx_sel_q, rx_sel_q};
      `ADDR_FIFO_CTL: rdata_d = 8'h00;
      `ADDR_TRIG_LVL: rdata_d = 8'h00;
      default: rdata_d = 8'h00;
    endcase
  end

  // registered outputs
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_out <= 8'h00;
      fifo_en_out <= 1'b0;
      dma_mode_out <= 1'b0;
      char_bits_out <= `RST_CHAR_BITS;
      stop_half_out <= 1'b0;
      stop_two_out <= 1'b0;
      parity_en_out <= 1'b0;
      parity_even_out <= 1'b0;
      rx_trig_out <= `RST_LEVEL;
      tx_trig_out <= `RST_LEVEL;
      irq_pending_out <= 1'b0;
    end
    else
    begin
      rdata_out <= rd_in ? rdata_d : 8'h00;
      fifo_en_out <= fifo_en_q;
      dma_mode_out <= dma_q;
      char_bits_out <= 4'h5 + {2'h0, line_fmt_q[1:0]};
      stop_half_out <= line_fmt_q[`LF_STOP] && len_five;
      stop_two_out <= line_fmt_q[`LF_STOP] && !len_five;
      parity_en_out <= line_fmt_q[`LF_PAR_EN];
      parity_even_out <= line_fmt_q[`LF_PAR_EN] && line_fmt_q[`LF_PAR_EVEN];
      rx_trig_out <= rx_lvl;
      tx_trig_out <= tx_lvl;
      irq_pending_out <= !id_code[0];
    end
  end

endmodule // uart_ctl_top

// ==== testbench/uart_ctl_monitor.sv ====
`timescale 1ns/1ps
module uart_ctl_monitor (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [2:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [7:0] rdata_out,
  input wire fifo_en_out,
  input wire dma_mode_out,
  input wire rx_fifo_rst_out,
  input wire tx_fifo_rst_out,
  input wire [3:0] char_bits_out,
  input wire stop_half_out,
  input wire stop_two_out,
  input wire parity_en_out,
  input wire parity_even_out,
  input wire irq_pending_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire fc_wr = wr_in && addr_in == 3'h1;
  wire lf_wr = wr_in && addr_in == 3'h2;
  AST_FIFO_EN: assert property (fc_wr |-> ##2 fifo_en_out == $past(wdata_in[0], 2))
    else $error("fifo enable mismatch");
  AST_DMA_SET: assert property (fc_wr && wdata_in[0] |-> ##2 dma_mode_out == $past(wdata_in[3], 2))
    else $error("dma mode mismatch");
  AST_DMA_IGNORED: assert property (fc_wr && !wdata_in[0] |-> ##2 $stable(dma_mode_out))
    else $error("dma mode changed on ignored write");
  AST_RX_RST: assert property (fc_wr && wdata_in[1] |=> rx_fifo_rst_out == $past(wdata_in[0]))
    else $error("rx fifo reset missing");
  AST_RX_ONLY: assert property (rx_fifo_rst_out |-> $past(fc_wr && wdata_in[1] && wdata_in[0]))
    else $error("rx fifo reset unexpected");
  AST_TX_ONLY: assert property (tx_fifo_rst_out |-> $past(fc_wr && wdata_in[2] && wdata_in[0]))
    else $error("tx fifo reset unexpected");
  AST_TX_RST: assert property (fc_wr && wdata_in[2] |=> tx_fifo_rst_out == $past(wdata_in[0]))
    else $error("tx fifo reset missing");
  AST_CHAR_LEN: assert property (lf_wr |-> ##2 char_bits_out == 4'h5 + $past(wdata_in[1:0], 2))
    else $error("character length mismatch");
  AST_STOP: assert property (lf_wr |-> ##2
    stop_two_out == ($past(wdata_in[2], 2) && $past(wdata_in[1:0], 2) != 2'h0)
    && stop_half_out == ($past(wdata_in[2], 2) && $past(wdata_in[1:0], 2) == 2'h0))
    else $error("stop bits mismatch");
  AST_PARITY: assert property (lf_wr |-> ##2
    parity_en_out == $past(wdata_in[3], 2)
    && parity_even_out == ($past(wdata_in[3], 2) && $past(wdata_in[4], 2)))
    else $error("parity mismatch");
  AST_FEN_READ: assert property (rd_in && addr_in == 3'h0 |=> rdata_out[7:6] == {2{fifo_en_out}})
    else $error("ident fifo bits mismatch");
  AST_IRQ_BIT0: assert property (rd_in && addr_in == 3'h0 |=> irq_pending_out == !rdata_out[0])
    else $error("pending flag disagrees with ident bit 0");
  cover property (rx_fifo_rst_out);
  cover property (tx_fifo_rst_out);
  cover property (rd_in && addr_in == 3'h0 ##1 irq_pending_out);
  cover property (lf_wr ##2 stop_half_out);
endmodule // uart_ctl_monitor

bind uart_ctl_top uart_ctl_monitor u_mon (.*);

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input wire core_clk_in,
  input wire [7:0] rdata_out,
  output reg [2:0] addr_in = 3'h0,
  output reg [7:0] wdata_in = 8'h00,
  output reg wr_in = 1'b0,
  output reg rd_in = 1'b0
);
  task wr(input [2:0] a, input [7:0] d);
  begin
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  end
  endtask
  task rd(input [2:0] a, output [7:0] d);
  begin
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  end
  endtask
endmodule // host_model

// ==== testbench/uart_irq_fifo_line_config_tb_top.sv ====
`timescale 1ns/1ps
module uart_irq_fifo_line_config_tb_top;
  reg core_clk_in = 1'b0;
  reg rst_n_in = 1'b0;
  reg line_status_in = 1'b0, rx_timeout_in = 1'b0, modem_status_in = 1'b0, xoff_det_in = 1'b0;
  reg cts_deassert_in = 1'b0, modem_read_in = 1'b0, thr_write_in = 1'b0;
  reg xon_det_in = 1'b0, special_det_in = 1'b0, rx_char_in = 1'b0, rts_deassert_in = 1'b0;
  reg [6:0] rx_count_in = 7'h00, tx_count_in = 7'h00;
  wire [2:0] addr_in;
  wire [7:0] wdata_in, rdata_out, rx_trig_out, tx_trig_out;
  wire [3:0] char_bits_out;
  wire wr_in, rd_in, fifo_en_out, dma_mode_out, rx_fifo_rst_out, tx_fifo_rst_out;
  wire stop_half_out, stop_two_out, parity_en_out, parity_even_out, irq_pending_out;
  integer num_errors = 0, comparisons = 0, cyc = 0, t, c;
  reg [7:0] rv, v;
  wire [7:0] fmt = {char_bits_out, stop_half_out, stop_two_out, parity_en_out, parity_even_out};
  byte rxl [12] = '{1, 4, 8, 14, 8, 16, 24, 28, 8, 16, 56, 60};
  byte txl [12] = '{1, 1, 1, 1, 16, 8, 24, 30, 8, 16, 32, 56};
  host_model u_host (.*);
  uart_ctl_top u_dut (.*);
  initial forever #20 core_clk_in = ~core_clk_in;
  task give_verdict;
  begin
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  always @(posedge core_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      num_errors = num_errors + 1;
    end
  end
  endtask
  task settle;
  begin
    repeat (2) @(posedge core_clk_in);
    #1;
  end
  endtask
  task id(input [7:0] exp);
  begin
    u_host.rd(3'h0, rv);
    chk(rv, exp);
  end
  endtask
  task src(input l, input r, input m);
  begin
    @(posedge core_clk_in);
    line_status_in <= l;
    rx_timeout_in <= r;
    modem_status_in <= m;
  end
  endtask
  task pulse(input [5:0] w);
  begin
    @(posedge core_clk_in);
    {xoff_det_in, modem_read_in, rts_deassert_in, rx_char_in, special_det_in, xon_det_in} <= w;
    @(posedge core_clk_in);
    {xoff_det_in, modem_read_in, rts_deassert_in, rx_char_in, special_det_in, xon_det_in} <= 6'h00;
  end
  endtask
  task t_reset;
  begin
    id(8'h01);
    chk({char_bits_out, stop_half_out, stop_two_out, parity_en_out, parity_even_out}, 8'h50);
    chk(rx_trig_out, 8'h01);
    chk(tx_trig_out, 8'h01);
  end
  endtask
  task t_fifo;
  begin
    u_host.wr(3'h1, 8'h0f);
    settle;
    chk({fifo_en_out, dma_mode_out}, 8'h03);
    id(8'hc1);
    u_host.wr(3'h1, 8'h06);
    settle;
    chk({fifo_en_out, dma_mode_out}, 8'h01);
    id(8'h01);
    u_host.wr(3'h1, 8'h01);
    settle;
    chk({fifo_en_out, dma_mode_out}, 8'h02);
    u_host.wr(3'h1, 8'h31);
    u_host.rd(3'h7, rv);
    chk(rv, 8'h00);
  end
  endtask
  task t_trig;
  begin
    u_host.wr(3'h3, 8'h10);
    for (t = 0; t < 3; t = t + 1)
      for (c = 0; c < 4; c = c + 1)
      begin
        u_host.wr(3'h5, {t[1:0], 4'h0});
        u_host.wr(3'h1, {c[1:0], c[1:0], 4'h1});
        settle;
        chk(rx_trig_out, rxl[t * 4 + c]);
        chk(tx_trig_out, txl[t * 4 + c]);
      end
    u_host.rd(3'h7, rv);
    chk(rv, 8'h0f);
    u_host.wr(3'h5, 8'h30);
    u_host.wr(3'h6, 8'h14);
    u_host.wr(3'h5, 8'hb0);
    u_host.wr(3'h6, 8'h28);
    settle;
    chk(rx_trig_out, 8'h14);
    chk(tx_trig_out, 8'h28);
  end
  endtask
  task t_line;
  begin
    for (t = 0; t < 32; t = t + 1)
    begin
      v = t;
      u_host.wr(3'h2, v);
      settle;
      chk(fmt, {4'h5 + v[1:0], v[2] && v[1:0] == 2'h0, v[2] && v[1:0] != 2'h0, v[3], v[3] && v[4]});
      u_host.rd(3'h2, rv);
      chk(rv, v);
    end
  end
  endtask
  task t_irq;
  begin
    u_host.wr(3'h4, 8'hff);
    src(1'b1, 1'b1, 1'b1);
    xoff_det_in <= 1'b1;
    cts_deassert_in <= 1'b1;
    @(posedge core_clk_in);
    xoff_det_in <= 1'b0;
    cts_deassert_in <= 1'b0;
    id(8'hc6);
    src(1'b0, 1'b1, 1'b1);
    id(8'hcc);
    src(1'b0, 1'b0, 1'b1);
    id(8'hc0);
    src(1'b0, 1'b0, 1'b0);
    id(8'hd0);
    id(8'he0);
    @(posedge core_clk_in);
    modem_read_in <= 1'b1;
    @(posedge core_clk_in);
    modem_read_in <= 1'b0;
    id(8'hc1);
    chk(irq_pending_out, 8'h00);
    pulse(6'h02);
    id(8'hd0);
    pulse(6'h02);
    pulse(6'h04);
    id(8'hc1);
    pulse(6'h06);
    id(8'hd0);
    pulse(6'h20);
    pulse(6'h01);
    id(8'hc1);
    pulse(6'h08);
    id(8'he0);
    pulse(6'h10);
    id(8'hc1);
    for (t = 0; t < 2; t = t + 1)
    begin
      @(posedge core_clk_in);
      tx_count_in <= 7'h32;
      settle;
      @(posedge core_clk_in);
      tx_count_in <= 7'h0a;
      settle;
      if (t == 0)
        id(8'hc2);
      else
      begin
        chk(irq_pending_out, 8'h01);
        @(posedge core_clk_in);
        thr_write_in <= 1'b1;
        @(posedge core_clk_in);
        thr_write_in <= 1'b0;
      end
      id(8'hc1);
    end
    @(posedge core_clk_in);
    tx_count_in <= 7'h00;
    settle;
    id(8'hc2);
    id(8'hc1);
    @(posedge core_clk_in);
    rx_count_in <= 7'h14;
    settle;
    id(8'hc4);
    @(posedge core_clk_in);
    rx_count_in <= 7'h13;
    settle;
    id(8'hc1);
  end
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_fifo;
    t_trig;
    t_line;
    t_irq;
    give_verdict;
  end
endmodule // uart_irq_fifo_line_config_tb_top
